//--- design/sbu_cond_eval.sv
// Condition evaluation for skip and branch operations
`timescale 1ns/1ps

module sbu_cond_eval
  import sbu_pkg::*;
(
  input wire sbu_op_e op,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] reg_data,
  input wire logic [7:0] io_data,
  input wire logic [7:0] flags,
  output logic is_skip,
  output logic is_branch,
  output logic cond
);

  always_comb begin
    is_skip = 1'b0;
    is_branch = 1'b1;
    cond = 1'b0;
    unique case (op)
      SBU_OP_NONE: begin
        is_branch = 1'b0;
      end
      // RQ1 register bit clear
      SBU_OP_SKIP_REG_BIT_CLEAR: begin
        is_skip = 1'b1;
        is_branch = 1'b0;
        cond = ~reg_data[bit_sel];
      end
      // RQ2 register bit set
      SBU_OP_SKIP_REG_BIT_SET: begin
        is_skip = 1'b1;
        is_branch = 1'b0;
        cond = reg_data[bit_sel];
      end
      // RQ3 io bit clear
      SBU_OP_SKIP_IO_BIT_CLEAR: begin
        is_skip = 1'b1;
        is_branch = 1'b0;
        cond = ~io_data[bit_sel];
      end
      // RQ4 io bit set
      SBU_OP_SKIP_IO_BIT_SET: begin
        is_skip = 1'b1;
        is_branch = 1'b0;
        cond = io_data[bit_sel];
      end
      // RQ5 generic flag set
      SBU_OP_BRANCH_FLAG_SET: cond = flags[bit_sel];
      // RQ6 generic flag clear
      SBU_OP_BRANCH_FLAG_CLEAR: cond = ~flags[bit_sel];
      // RQ7 zero flag tests
      SBU_OP_BRANCH_EQUAL: cond = flags[SBU_FLAG_Z];
      SBU_OP_BRANCH_NOT_EQUAL: cond = ~flags[SBU_FLAG_Z];
      // RQ8 carry flag tests
      SBU_OP_BRANCH_CARRY_SET,
      SBU_OP_BRANCH_LOWER: cond = flags[SBU_FLAG_C];
      SBU_OP_BRANCH_CARRY_CLEAR,
      SBU_OP_BRANCH_SAME_OR_HIGHER: cond = ~flags[SBU_FLAG_C];
      // RQ9 negative flag tests
      SBU_OP_BRANCH_MINUS: cond = flags[SBU_FLAG_N];
      SBU_OP_BRANCH_PLUS: cond = ~flags[SBU_FLAG_N];
      // RQ10 signed compare
      SBU_OP_BRANCH_SIGNED_GE: cond = ~(flags[SBU_FLAG_N] ^ flags[SBU_FLAG_V]);
      SBU_OP_BRANCH_SIGNED_LT: cond = flags[SBU_FLAG_N] ^ flags[SBU_FLAG_V];
      // RQ11 half carry test
      SBU_OP_BRANCH_HALF_CARRY_SET: cond = flags[SBU_FLAG_H];
      default: begin
        is_branch = 1'b0;
      end
    endcase
  end

endmodule : sbu_cond_eval

//--- design/sbu_pkg.sv
// Shared types and constants for the skip and branch unit
package sbu_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned SBU_PC_W = 16;
  localparam int unsigned SBU_K_W = 7;

  // ==========================================================
  // Status flag bit positions
  localparam logic [2:0] SBU_FLAG_C = 3'h0;
  localparam logic [2:0] SBU_FLAG_Z = 3'h1;
  localparam logic [2:0] SBU_FLAG_N = 3'h2;
  localparam logic [2:0] SBU_FLAG_V = 3'h3;
  localparam logic [2:0] SBU_FLAG_H = 3'h5;

  // ==========================================================
  // Step sizes and reset values
  localparam logic [1:0] SBU_SKIP_ONE = 2'h2;
  localparam logic [1:0] SBU_SKIP_TWO = 2'h3;
  localparam logic [1:0] SBU_EXTRA_RESET = 2'h0;

  // ==========================================================
  // Operations
  typedef enum logic [4:0] {
    SBU_OP_NONE,
    SBU_OP_SKIP_REG_BIT_CLEAR,
    SBU_OP_SKIP_REG_BIT_SET,
    SBU_OP_SKIP_IO_BIT_CLEAR,
    SBU_OP_SKIP_IO_BIT_SET,
    SBU_OP_BRANCH_FLAG_SET,
    SBU_OP_BRANCH_FLAG_CLEAR,
    SBU_OP_BRANCH_EQUAL,
    SBU_OP_BRANCH_NOT_EQUAL,
    SBU_OP_BRANCH_CARRY_SET,
    SBU_OP_BRANCH_CARRY_CLEAR,
    SBU_OP_BRANCH_SAME_OR_HIGHER,
    SBU_OP_BRANCH_LOWER,
    SBU_OP_BRANCH_MINUS,
    SBU_OP_BRANCH_PLUS,
    SBU_OP_BRANCH_SIGNED_GE,
    SBU_OP_BRANCH_SIGNED_LT,
    SBU_OP_BRANCH_HALF_CARRY_SET
  } sbu_op_e;

  // Decoded instruction handed over by fetch
  typedef struct packed {
    sbu_op_e op;
    logic [2:0] bit_sel;
    logic [SBU_K_W-1:0] offset;
    logic next_is_two_word;
  } sbu_instr_s;

  // Program counter result towards fetch
  typedef struct packed {
    logic load;
    logic [SBU_PC_W-1:0] pc;
  } sbu_pc_s;

endpackage : sbu_pkg

//--- design/sbu_skip_branch_unit.sv
// Skip and conditional relative branch unit of the core
// Function
// RQ1 - Register bit clear skip advances PC by 2 or 3 when bit is zero.
// RQ2 - Register bit set skip advances PC by 2 or 3 when bit is one.
// RQ3 - I/O bit clear skip advances PC by 2 or 3 when bit is zero.
// RQ4 - I/O bit set skip advances PC by 2 or 3 when bit is one.
// RQ5 - Generic flag-set branch loads PC plus k plus 1 when flag s is one.
// RQ6 - Generic flag-clear branch loads PC plus k plus 1 when flag s is zero.
// RQ7 - Equal branches on zero flag one; not-equal on zero flag zero.
// RQ8 - Carry-set and lower take on carry one; clear and same-or-higher on zero.
// RQ9 - Minus branches on negative flag one; plus on negative flag zero.
// RQ10 - Signed ge branches when N xor V is zero; signed lt when one.
// RQ11 - A dedicated branch is taken when half-carry flag is set.
// RQ12 - No skip or branch alters any status flag.
// RQ13 - Bit-test skips take 1, 2 or 3 cycles.
// RQ14 - Branches take 1 cycle untaken, 2 cycles taken.
// RQ15 - Skipping one word costs two cycles, two words three cycles.
// RQ16 - Offset k is signed words, sign-extended to PC width before adding.
`timescale 1ns/1ps

module sbu_skip_branch_unit
  import sbu_pkg::*;
#(
  parameter int unsigned PC_W = SBU_PC_W,
  parameter int unsigned K_W = SBU_K_W
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire sbu_instr_s instr,
  input wire logic [PC_W-1:0] pc_now,
  input wire logic [7:0] reg_data,
  input wire logic [7:0] io_data,
  input wire logic [7:0] status_flags_register,
  output logic busy,
  output logic done,
  output logic taken,
  output logic pc_load,
  output logic [PC_W-1:0] pc_next,
  output logic flags_write
);

  // ==========================================================
  // Condition decode
  logic is_skip;
  logic is_branch;
  logic cond;

  sbu_cond_eval u_cond (
    .op(instr.op),
    .bit_sel(instr.bit_sel),
    .reg_data(reg_data),
    .io_data(io_data),
    .flags(status_flags_register),
    .is_skip(is_skip),
    .is_branch(is_branch),
    .cond(cond)
  );

  // ==========================================================
  // Target arithmetic
  logic [PC_W-1:0] k_ext;
  logic [PC_W-1:0] branch_target;
  logic [PC_W-1:0] skip_target;

  always_comb begin
    // RQ16 sign extension
    k_ext = {{(PC_W-K_W){instr.offset[K_W-1]}}, instr.offset};
    // RQ5 target is PC plus k plus 1
    branch_target = pc_now + k_ext + PC_W'(1);
    // RQ15 skip distance from next word length
    skip_target = pc_now + PC_W'(instr.next_is_two_word ? SBU_SKIP_TWO : SBU_SKIP_ONE);
  end

  // ==========================================================
  // Sequencer: extra cycles burnt while a taken skip or branch resolves
  typedef enum logic [1:0] {SBU_IDLE, SBU_WAIT} sbu_state_e;

  sbu_state_e state_q, state_d;
  logic [1:0] extra_q, extra_d;
  logic accept;
  logic go_wait;
  logic last_wait;

  // Requests seen while a taken op resolves are dropped; no port reports it
  always_comb begin
    accept = 1'b0;
    if (state_q == SBU_IDLE) begin
      accept = instr_valid && (is_skip || is_branch);
    end
    go_wait = accept && cond;
    // Last wait cycle is the one that raises load and done
    last_wait = (state_q == SBU_WAIT) && (extra_q == SBU_EXTRA_RESET);
  end

  // Skips share the branch wait state; only the count differs
  always_comb begin
    state_d = state_q;
    extra_d = extra_q;
    unique case (state_q)
      SBU_IDLE: begin
        if (go_wait) begin
          state_d = SBU_WAIT;
          // RQ15 two-word skip waits longer
          if (is_skip && instr.next_is_two_word) begin
            extra_d = 2'h1;
          end else begin
            extra_d = 2'h0;
          end
        end
      end
      SBU_WAIT: begin
        if (last_wait) begin
          state_d = SBU_IDLE;
        end else begin
          extra_d = extra_q - 2'h1;
        end
      end
      default: begin
        state_d = SBU_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_q <= SBU_IDLE;
      extra_q <= SBU_EXTRA_RESET;
    end else begin
      state_q <= state_d;
      extra_q <= extra_d;
    end
  end

  // ==========================================================
  // Completion status towards fetch
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic taken_q, taken_d;
  logic load_q, load_d;
  logic flags_write_q, flags_write_d;

  always_comb begin
    busy_d = 1'b0;
    done_d = 1'b0;
    // Taken stays valid until the next accepted op
    taken_d = taken_q;
    load_d = 1'b0;
    // RQ12 flags never written
    flags_write_d = 1'b0;
    unique case (state_q)
      SBU_IDLE: begin
        if (accept) begin
          taken_d = cond;
          // RQ13 untaken finishes in one cycle
          done_d = !cond;
          // RQ14 taken op stays busy
          busy_d = cond;
        end
      end
      SBU_WAIT: begin
        // RQ13 final cycle loads the new PC
        load_d = last_wait;
        done_d = last_wait;
        busy_d = !last_wait;
      end
      default: begin
        busy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      taken_q <= 1'b0;
      load_q <= 1'b0;
      flags_write_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
      taken_q <= taken_d;
      load_q <= load_d;
      flags_write_q <= flags_write_d;
    end
  end

  // ==========================================================
  // Target register, held until the next taken op
  logic [PC_W-1:0] pc_q, pc_d;

  // Fetch reads the target only while load is high
  always_comb begin
    pc_d = pc_q;
    if (go_wait) begin
      // RQ14 target latched on the first cycle
      if (is_branch) begin
        pc_d = branch_target;
      end else begin
        pc_d = skip_target;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pc_q <= '0;
    end else begin
      pc_q <= pc_d;
    end
  end

  // ==========================================================
  // Outputs, each straight from a flip-flop
  assign busy = busy_q;
  assign done = done_q;
  assign taken = taken_q;
  assign pc_load = load_q;
  assign pc_next = pc_q;
  assign flags_write = flags_write_q;

endmodule : sbu_skip_branch_unit

//--- dv/sbu_asserts.sv
// Port checker for the skip and branch unit
`timescale 1ns/1ps
module sbu_asserts
  import sbu_pkg::*;
#(
  parameter int unsigned PC_W = SBU_PC_W
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire sbu_instr_s instr,
  input wire logic [PC_W-1:0] pc_now,
  input wire logic [7:0] status_flags_register,
  input wire logic busy,
  input wire logic done,
  input wire logic taken,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_next,
  input wire logic flags_write
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ==========
  // Accepted requests
  sequence s_acc;
    instr_valid && instr.op != SBU_OP_NONE && !busy;
  endsequence
  sequence s_br_t;
    (s_acc ##0 instr.op >= SBU_OP_BRANCH_FLAG_SET) ##1 taken;
  endsequence
  sequence s_sk2_t;
    (s_acc ##0 instr.op < SBU_OP_BRANCH_FLAG_SET && instr.next_is_two_word) ##1 taken;
  endsequence
  a_flags_untouched: assert property (!flags_write)
    else $error("flags write seen");
  a_equal_cond: assert property (s_acc ##0 instr.op == SBU_OP_BRANCH_EQUAL
    |=> taken == $past(status_flags_register[1])) else $error("equal condition wrong");
  a_signed_lt: assert property (s_acc ##0 instr.op == SBU_OP_BRANCH_SIGNED_LT
    |=> taken == $past(^status_flags_register[3:2])) else $error("signed lt wrong");
  a_untaken_one: assert property (s_acc ##1 !taken |-> done && !busy)
    else $error("untaken not one cycle");
  a_branch_two: assert property (s_br_t |-> busy ##1 (pc_load && done))
    else $error("taken branch not two cycles");
  a_branch_target: assert property (s_br_t |-> pc_next ==
    PC_W'($past(pc_now) + PC_W'(signed'($past(instr.offset))) + 1)) else $error("bad target");
  a_skip_three: assert property (s_sk2_t |-> busy ##1 busy ##1
    (pc_load && pc_next == PC_W'($past(pc_now, 3) + 3))) else $error("bad long skip");
  a_load_once: assert property (pc_load |=> !pc_load)
    else $error("load held");
endmodule : sbu_asserts

bind sbu_skip_branch_unit sbu_asserts #(.PC_W(PC_W)) sbu_asserts_inst (.ref_clk(ref_clk),
  .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr), .pc_now(pc_now),
  .status_flags_register(status_flags_register), .busy(busy), .done(done), .taken(taken),
  .pc_load(pc_load), .pc_next(pc_next), .flags_write(flags_write));

//--- dv/sbu_fetch_model.sv
// Fetch stage model that owns the program counter
`timescale 1ns/1ps
module sbu_fetch_model
  import sbu_pkg::*;
#(
  parameter logic [SBU_PC_W-1:0] PC_INIT = 16'hffe0
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic done,
  input wire logic pc_load,
  input wire logic [SBU_PC_W-1:0] pc_next,
  output logic [SBU_PC_W-1:0] pc_q
);
  logic [SBU_PC_W-1:0] pc_d;
  // Start near the top so targets wrap
  always_comb begin
    pc_d = pc_load ? pc_next : pc_q + SBU_PC_W'(done);
  end
  always_ff @(posedge ref_clk) begin
    pc_q <= rst_b ? pc_d : PC_INIT;
  end
endmodule : sbu_fetch_model

//--- dv/sbu_skip_branch_unit_tb_top.sv
// Self-checking testbench for the skip and branch unit
`timescale 1ns/1ps
module sbu_skip_branch_unit_tb_top
  import sbu_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic instr_valid = 1'b0;
  logic busy, done, taken, pc_load, flags_write;
  logic [SBU_PC_W-1:0] pc_now, pc_next;
  logic [7:0] reg_data = 8'h00;
  logic [7:0] io_data = 8'h00;
  logic [7:0] status_flags_register = 8'h00;
  sbu_instr_s instr = '0;
  int n_mismatch = 0;
  int n_tests = 0;

  sbu_skip_branch_unit sbu_skip_branch_unit_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .instr_valid(instr_valid), .instr(instr), .pc_now(pc_now), .reg_data(reg_data),
    .io_data(io_data), .status_flags_register(status_flags_register), .busy(busy),
    .done(done), .taken(taken), .pc_load(pc_load), .pc_next(pc_next),
    .flags_write(flags_write));
  sbu_fetch_model sbu_fetch_model_inst (.ref_clk(ref_clk), .rst_b(rst_b), .done(done),
    .pc_load(pc_load), .pc_next(pc_next), .pc_q(pc_now));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic cond_of(sbu_op_e op, logic [2:0] b, logic [7:0] rd,
                                   logic [7:0] io, logic [7:0] f);
    case (op)
      SBU_OP_SKIP_REG_BIT_CLEAR: return !rd[b];
      SBU_OP_SKIP_REG_BIT_SET: return rd[b];
      SBU_OP_SKIP_IO_BIT_CLEAR: return !io[b];
      SBU_OP_SKIP_IO_BIT_SET: return io[b];
      SBU_OP_BRANCH_FLAG_SET: return f[b];
      SBU_OP_BRANCH_FLAG_CLEAR: return !f[b];
      SBU_OP_BRANCH_EQUAL: return f[SBU_FLAG_Z];
      SBU_OP_BRANCH_NOT_EQUAL: return !f[SBU_FLAG_Z];
      SBU_OP_BRANCH_CARRY_SET, SBU_OP_BRANCH_LOWER: return f[SBU_FLAG_C];
      SBU_OP_BRANCH_CARRY_CLEAR, SBU_OP_BRANCH_SAME_OR_HIGHER: return !f[SBU_FLAG_C];
      SBU_OP_BRANCH_MINUS: return f[SBU_FLAG_N];
      SBU_OP_BRANCH_PLUS: return !f[SBU_FLAG_N];
      SBU_OP_BRANCH_SIGNED_GE: return !(f[SBU_FLAG_N] ^ f[SBU_FLAG_V]);
      SBU_OP_BRANCH_SIGNED_LT: return f[SBU_FLAG_N] ^ f[SBU_FLAG_V];
      default: return f[SBU_FLAG_H];
    endcase
  endfunction : cond_of

  // ==========
  // One operation, entered and left at a falling edge
  task automatic run(sbu_op_e op, logic [2:0] b, logic [6:0] k, logic tw,
                     logic [7:0] rd, logic [7:0] io, logic [7:0] fl);
    logic c;
    logic sk;
    logic [15:0] pe;
    int n;
    c = cond_of(op, b, rd, io, fl);
    sk = op < SBU_OP_BRANCH_FLAG_SET;
    pe = sk ? pc_now + (tw ? 16'h0003 : 16'h0002) : pc_now + {{9{k[6]}}, k} + 16'h0001;
    instr = '{op, b, k, tw};
    reg_data = rd;
    io_data = io;
    status_flags_register = fl;
    instr_valid = 1'b1;
    @(negedge ref_clk);
    n = 1;
    check("busy", c, busy);
    // Untaken ops keep the strobe up for back-to-back issue
    if (done !== 1'b1) instr_valid = 1'b0;
    while (done !== 1'b1 && n < 9) begin
      @(negedge ref_clk);
      n++;
    end
    check("cycles", !c ? 1 : (sk && tw) ? 3 : 2, n);
    check("taken", c, taken);
    check("pc_load", c, pc_load);
    if (c) check("pc_next", pe, pc_next);
    check("flags_write", 0, flags_write);
  endtask : run

  task automatic sc_skips();
    for (int i = 1; i < 5; i++) begin
      for (int j = 0; j < 4; j++) begin
        run(sbu_op_e'(i), 3'h6, 7'h00, j[1], j[0] ? 8'h40 : 8'hbf, j[0] ? 8'hbf : 8'h40, 8'hff);
      end
    end
  endtask : sc_skips

  task automatic sc_branches();
    logic [7:0] pat [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h0c, 8'h20, 8'hdf};
    for (int i = 5; i < 18; i++) begin
      for (int j = 0; j < 8; j++) begin
        run(sbu_op_e'(i), 3'(j), j[0] ? 7'h40 : 7'h3f, 1'b0, 8'h00, 8'h00, pat[j]);
      end
    end
  endtask : sc_branches

  task automatic sc_reset();
    instr = '{SBU_OP_SKIP_IO_BIT_SET, 3'h0, 7'h00, 1'b1};
    io_data = 8'h01;
    instr_valid = 1'b1;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    rst_b = 1'b0;
    @(negedge ref_clk);
    check("reset outputs", 0, {busy, done, taken, pc_load, pc_next, flags_write});
    rst_b = 1'b1;
    run(SBU_OP_BRANCH_EQUAL, 3'h0, 7'h01, 1'b0, 8'h00, 8'h00, 8'h02);
  endtask : sc_reset

  task automatic print_verdict();
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    sc_skips();
    sc_branches();
    sc_reset();
    print_verdict();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    n_mismatch++;
    print_verdict();
  end
endmodule : sbu_skip_branch_unit_tb_top
